/* File: core/cmbg_regs.vh */
// register offsets, field positions and reset values of the clock mux and rate divider
`ifndef CMBG_REGS_VH
`define CMBG_REGS_VH
`define CMBG_OFF_CLK_MODE   8'h00
`define CMBG_OFF_RATE_LO    8'h04
`define CMBG_OFF_RATE_HI    8'h08
`define CMBG_OFF_DIV_CTRL   8'h0c
`define CMBG_OFF_EXT_EN     8'h10
`define CMBG_OFF_STATUS     8'h14
`define CMBG_OFF_MODE_CFG   8'h18
`define CMBG_XTAL_BIT       7
`define CMBG_RXSEL_HI       6
`define CMBG_RXSEL_LO       5
`define CMBG_TXSEL_HI       4
`define CMBG_TXSEL_LO       3
`define CMBG_BOUT_EN_BIT    2
`define CMBG_BSEL_HI        1
`define CMBG_BSEL_LO        0
`define CMBG_DIV_EN_BIT     0
`define CMBG_DIV_PCLK_BIT   1
`define CMBG_ZC_IE_BIT      1
`define CMBG_ASYNC_BIT      0
`define CMBG_EXTSYNC_BIT    1
`define CMBG_ST_ZC_BIT      1
`define CMBG_ST_SYNC_BIT    4
`define CMBG_ST_DIVOUT_BIT  0
`define CMBG_SRC_RX_TX_CLOCK_PIN       2'h0
`define CMBG_SRC_BIDIR_CLOCK_PIN       2'h1
`define CMBG_SRC_DIV        2'h2
`define CMBG_SRC_LOOP       2'h3
`define CMBG_OUT_XTAL       2'h0
`define CMBG_OUT_DIV        2'h1
`define CMBG_OUT_LOOP       2'h2
`define CMBG_OUT_TXCLK      2'h3
`define CMBG_CLK_MODE_RST   8'h00
`define CMBG_DIV_CTRL_RST   8'h00
`define CMBG_EXT_EN_RST     8'h00
`define CMBG_MODE_CFG_RST   8'h00
`define CMBG_TC_LO_RST      8'h00
`define CMBG_TC_HI_RST      8'h00
`endif

/* File: core/cmbg_divider.v */
// 16-bit reloading down counter with square-wave output and zero-count flag
module cmbg_divider #(
  parameter WIDTH = 16
) (
  hclk,
  hresetn,
  div_tick,
  div_en,
  time_const,
  div_out,
  zero_cnt
);
  input  wire             hclk;
  input  wire             hresetn;
  input  wire             div_tick;
  input  wire             div_en;
  input  wire [WIDTH-1:0] time_const;
  output reg              div_out;
  output wire             zero_cnt;

  reg  [WIDTH-1:0] count_r;
  reg  [1:0]       en_sync_r;
  reg              running_r;

  // zero flag while the counter sits at zero; reset forces it active
  assign zero_cnt = (count_r == {WIDTH{1'b0}});

  // enable is resynced over two divider ticks; disable acts at once
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_sync_r <= 2'b00;
      running_r <= 1'b0;
      count_r   <= {WIDTH{1'b0}};
      div_out   <= 1'b1;
    end else if (!div_en) begin
      en_sync_r <= 2'b00; // [RULE_23]
      running_r <= 1'b0;
    end else if (div_tick) begin
      en_sync_r <= {en_sync_r[0], 1'b1}; // [RULE_23]
      if (en_sync_r[1] && !running_r) begin
        running_r <= 1'b1;
        div_out   <= 1'b1; // [RULE_14]
        count_r   <= time_const;
      end else if (running_r) begin
        if (zero_cnt) begin
          div_out <= ~div_out; // [RULE_15]
          count_r <= time_const;
        end else begin
          count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1}; // [RULE_13]
        end
      end
    end
  end
endmodule // cmbg_divider

/* File: core/cmbg_top.v */
// clock source multiplexers, crystal control and bit-rate divider behind an ahb-lite slave
//
// Contract
// [RULE_01] clock mode bit seven enables crystal amplifier
// [RULE_02] crystal output replaces rx/tx clock pin source
// [RULE_03] crystal on: no sync output, no external sync
// [RULE_04] async with crystal: sync status reads zero
// [RULE_05] software waits oscillator settling before use
// [RULE_06] bits six-five pick receive clock source
// [RULE_07] bits four-three pick transmit clock source
// [RULE_08] bidir pin output only if unused, bit two
// [RULE_09] bits one-zero pick bidir pin output signal
// [RULE_10] crystal selected but off drives pin high
// [RULE_11] rising pin edge samples receive data
// [RULE_12] software sets sources before enabling users
// [RULE_13] sixteen-bit constant, down counter, square output
// [RULE_14] start-up sets output high, loads constant
// [RULE_15] zero count toggles output and reloads
// [RULE_16] zero-count status active while counter zero
// [RULE_17] zero status gated by enable, reset active
// [RULE_18] software stops divider before changing constant
// [RULE_19] low byte first register, high byte second
// [RULE_20] divider output may drive idle bidir pin
// [RULE_21] software enables divider, reset disables it
// [RULE_22] divider control bit one picks processor clock
// [RULE_23] enable synced, two-count delay, immediate disable
`include "cmbg_regs.vh"
module cmbg_top #(
  parameter TC_WIDTH = 16
) (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hrdata,
  hreadyout,
  hresp,
  rx_tx_clock_pin_in,
  bidir_clock_pin_in,
  bidir_clock_pin_out,
  bidir_clock_pin_oe,
  sync_in,
  sync_pulse_in,
  loop_rx_clk,
  loop_tx_clk,
  xtal_osc_in,
  xtal_amp_en,
  rx_clk,
  tx_clk,
  sync_out,
  sync_oe,
  ext_sync_mode,
  div_out,
  zero_count
);
  input  wire        hclk;
  input  wire        hresetn;
  input  wire        hsel;
  input  wire [7:0]  haddr;
  input  wire [1:0]  htrans;
  input  wire        hwrite;
  input  wire [2:0]  hsize;
  input  wire [31:0] hwdata;
  input  wire        hready;
  output reg  [31:0] hrdata;
  output wire        hreadyout;
  output wire        hresp;
  input  wire        rx_tx_clock_pin_in;
  input  wire        bidir_clock_pin_in;
  output reg         bidir_clock_pin_out;
  output reg         bidir_clock_pin_oe;
  input  wire        sync_in;
  input  wire        sync_pulse_in;
  input  wire        loop_rx_clk;
  input  wire        loop_tx_clk;
  input  wire        xtal_osc_in;
  output reg         xtal_amp_en;
  output reg         rx_clk;
  output reg         tx_clk;
  output reg         sync_out;
  output reg         sync_oe;
  output reg         ext_sync_mode;
  output wire        div_out;
  output wire        zero_count;

  // software-visible registers
  reg  [7:0]          clock_mode_control_r;
  reg  [7:0]          rate_constant_low_r;
  reg  [7:0]          rate_constant_high_r;
  reg  [7:0]          divider_and_recovery_control_r;
  reg  [7:0]          ext_status_enable_register_r;
  reg  [7:0]          mode_cfg_r;
  // ahb data-phase bookkeeping
  reg                 wr_pend_r;
  reg                 rd_pend_r;
  reg  [7:0]          addr_r;
  // pin samples and edge detection for the divider clock, the receive edge and the sync status
  reg                 div_src_r;
  reg                 div_src_d_r;
  reg                 rx_clk_d_r;
  reg                 sync_stat_r;
  wire                xtal_on;
  wire                rx_tx_clock_pin_eff;
  wire                div_clk_pin;
  wire                div_tick;
  wire                zc_raw;
  wire [TC_WIDTH-1:0] time_const;
  wire                ahb_go;
  wire [1:0]          rx_sel;
  wire [1:0]          tx_sel;
  wire [1:0]          out_sel;
  wire                bidir_clock_pin_used;
  wire                async_mode;
  reg                 rx_sample_edge;

  assign xtal_on    = clock_mode_control_r[`CMBG_XTAL_BIT];
  assign rx_sel     = clock_mode_control_r[`CMBG_RXSEL_HI:`CMBG_RXSEL_LO];
  assign tx_sel     = clock_mode_control_r[`CMBG_TXSEL_HI:`CMBG_TXSEL_LO];
  assign out_sel    = clock_mode_control_r[`CMBG_BSEL_HI:`CMBG_BSEL_LO];
  assign async_mode = mode_cfg_r[`CMBG_ASYNC_BIT];

  // crystal on replaces every use of the rx/tx clock pin
  assign rx_tx_clock_pin_eff = xtal_on ? xtal_osc_in : rx_tx_clock_pin_in; // [RULE_02]

  // low byte from the first constant register, high from the second
  // not resynced to the divider clock: stop the divider before changing it
  assign time_const = {rate_constant_high_r, rate_constant_low_r}; // [RULE_19]

  // ahb-lite: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ahb_go    = hsel & hready & htrans[1];

  // address phase capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= ahb_go & hwrite;
      rd_pend_r <= ahb_go & ~hwrite;
      if (ahb_go)
        addr_r <= haddr;
    end
  end

  // register writes in the data phase
  // hsize is ignored: every register takes the low byte of a whole word
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_mode_control_r           <= `CMBG_CLK_MODE_RST;
      rate_constant_low_r            <= `CMBG_TC_LO_RST;
      rate_constant_high_r           <= `CMBG_TC_HI_RST;
      divider_and_recovery_control_r <= `CMBG_DIV_CTRL_RST; // [RULE_21]
      ext_status_enable_register_r   <= `CMBG_EXT_EN_RST;
      mode_cfg_r                     <= `CMBG_MODE_CFG_RST;
    end else if (wr_pend_r) begin
      case (addr_r)
        `CMBG_OFF_CLK_MODE: clock_mode_control_r <= hwdata[7:0];
        `CMBG_OFF_RATE_LO:  rate_constant_low_r  <= hwdata[7:0];
        `CMBG_OFF_RATE_HI:  rate_constant_high_r <= hwdata[7:0];
        `CMBG_OFF_DIV_CTRL: divider_and_recovery_control_r <= hwdata[7:0]; // [RULE_21]
        `CMBG_OFF_EXT_EN:   ext_status_enable_register_r <= hwdata[7:0];
        `CMBG_OFF_MODE_CFG: mode_cfg_r <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // status word: zero-count gated by its enable, sync is the inverted pin unless crystal on in async mode
  wire zc_status;
  assign zc_status  = zc_raw & ext_status_enable_register_r[`CMBG_ZC_IE_BIT]; // [RULE_17]
  assign zero_count = zc_raw; // [RULE_16]

  // read mux; write-only registers read back as zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ahb_go & ~hwrite) begin
      hrdata <= 32'h00000000;
      // status is taken in the address phase and stands through the data phase
      case (haddr)
        `CMBG_OFF_STATUS: begin
          hrdata[`CMBG_ST_ZC_BIT]     <= zc_status;
          hrdata[`CMBG_ST_SYNC_BIT]   <= sync_stat_r;
          hrdata[`CMBG_ST_DIVOUT_BIT] <= div_out;
        end
        default: ;
      endcase
    end
  end

  // sync status: inverted pin level, or zero in async mode with crystal on
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      sync_stat_r <= 1'b0;
    else if (xtal_on && async_mode)
      sync_stat_r <= 1'b0; // [RULE_04]
    else
      sync_stat_r <= ~sync_in;
  end

  // divider clock source: processor clock or the external pin
  // the pin is sampled by hclk, so a pin clock must stay below half the hclk rate
  assign div_clk_pin = bidir_clock_pin_in; // pin input regardless of crystal use

  // pin sample
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      div_src_r <= 1'b0;
    else
      div_src_r <= div_clk_pin;
  end

  // delayed pin sample for rising edge detection
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      div_src_d_r <= 1'b0;
    else
      div_src_d_r <= div_src_r;
  end
  // processor clock gives a tick every cycle; the pin gives one per rising edge
  assign div_tick = divider_and_recovery_control_r[`CMBG_DIV_PCLK_BIT] ? 1'b1 : // [RULE_22]
                    (div_src_r & ~div_src_d_r);

  cmbg_divider #(
    .WIDTH (TC_WIDTH)
  ) i_cmbg_divider (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .div_tick   (div_tick),
    .div_en     (divider_and_recovery_control_r[`CMBG_DIV_EN_BIT]),
    .time_const (time_const),
    .div_out    (div_out),
    .zero_cnt   (zc_raw)
  );

  // bidir pin in use as a clock source by either side
  assign bidir_clock_pin_used = (rx_sel == `CMBG_SRC_BIDIR_CLOCK_PIN) | (tx_sel == `CMBG_SRC_BIDIR_CLOCK_PIN);

  // source function shared by both clock multiplexers
  function src_pick;
    input [1:0] sel;
    input       rt;
    input       tr;
    input       dv;
    input       lp;
    begin
      case (sel)
        `CMBG_SRC_RX_TX_CLOCK_PIN: src_pick = rt;
        `CMBG_SRC_BIDIR_CLOCK_PIN: src_pick = tr;
        `CMBG_SRC_DIV:  src_pick = dv;
        default:        src_pick = lp;
      endcase
    end
  endfunction

  // receive clock multiplexer, registered so the output comes from a flip-flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rx_clk <= 1'b0;
    else
      rx_clk <= src_pick(rx_sel, rx_tx_clock_pin_eff, bidir_clock_pin_in, div_out, loop_tx_clk); // [RULE_06]
  end

  // transmit clock multiplexer, fed by the same four sources
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tx_clk <= 1'b0;
    else
      tx_clk <= src_pick(tx_sel, rx_tx_clock_pin_eff, bidir_clock_pin_in, div_out, loop_tx_clk); // [RULE_07]
  end

  // bidir pin direction: output only while neither clock takes it as source
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      bidir_clock_pin_oe <= 1'b0;
    else
      bidir_clock_pin_oe <= ~bidir_clock_pin_used & clock_mode_control_r[`CMBG_BOUT_EN_BIT]; // [RULE_08]
  end

  // bidir pin drive value, high out of reset so enabling shows no false edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bidir_clock_pin_out <= 1'b1;
    end else begin
      case (out_sel)
        `CMBG_OUT_XTAL:  bidir_clock_pin_out <= xtal_on ? xtal_osc_in : 1'b1; // [RULE_10]
        `CMBG_OUT_DIV:   bidir_clock_pin_out <= div_out; // [RULE_20]
        `CMBG_OUT_LOOP:  bidir_clock_pin_out <= loop_rx_clk; // [RULE_09]
        `CMBG_OUT_TXCLK: bidir_clock_pin_out <= tx_clk; // [RULE_09]
        default:         bidir_clock_pin_out <= 1'b1;
      endcase
    end
  end

  // receive sampling edge: rising pin edge, found as a rising edge of the registered rx_clk
  always @* begin
    rx_sample_edge = rx_clk & ~rx_clk_d_r; // [RULE_11]
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rx_clk_d_r <= 1'b0;
    else
      rx_clk_d_r <= rx_clk;
  end

  // sync pulse request, dropped while the sync pin feeds the crystal
  wire sync_pulse_ok;
  assign sync_pulse_ok = sync_pulse_in & rx_sample_edge & ~xtal_on; // [RULE_03]

  // crystal amplifier follows clock mode bit seven
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      xtal_amp_en <= 1'b0;
    else
      xtal_amp_en <= xtal_on; // [RULE_01]
  end

  // sync pin drives only in synchronous modes while the crystal is off
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      sync_oe <= 1'b0;
    else
      sync_oe <= ~xtal_on & ~async_mode & ~mode_cfg_r[`CMBG_EXTSYNC_BIT]; // [RULE_03]
  end

  // sync pulse is active low, one cycle per receive sampling edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      sync_out <= 1'b1;
    else
      sync_out <= ~sync_pulse_ok; // [RULE_03]
  end

  // external sync may only be chosen while the crystal is off
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ext_sync_mode <= 1'b0;
    else
      ext_sync_mode <= ~xtal_on & mode_cfg_r[`CMBG_EXTSYNC_BIT]; // [RULE_03]
  end
endmodule // cmbg_top

/* File: test/cmbg_top_asserts.sv */
// port checker for the clock mux and rate divider, bound to the top
module cmbg_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        rx_tx_clock_pin_in,
  input wire        bidir_clock_pin_in,
  input wire        bidir_clock_pin_out,
  input wire        bidir_clock_pin_oe,
  input wire        loop_tx_clk,
  input wire        xtal_osc_in,
  input wire        xtal_amp_en,
  input wire        rx_clk,
  input wire        tx_clk,
  input wire        sync_out,
  input wire        ext_sync_mode,
  input wire        div_out,
  input wire        zero_count
);
  reg        wr_r;
  reg        ex_rx_r;
  reg        ex_tx_r;
  reg  [7:0] cm_r;
  reg  [7:0] cm_d_r;
  reg  [7:0] cm_d2_r;
  // clock mode held for two cycles, so registered outputs have caught up
  wire       stab = (cm_r == cm_d_r) && (cm_d_r == cm_d2_r);
  // shadow of the clock mode register; d2 resets apart to mask the first edges
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      cm_r <= 8'h00;
      cm_d_r <= 8'h00;
      cm_d2_r <= 8'hff;
    end else begin
      wr_r <= hsel && hready && htrans[1] && hwrite && (haddr == 8'h00);
      if (wr_r) cm_r <= hwdata[7:0];
      cm_d_r <= cm_r;
      cm_d2_r <= cm_d_r;
    end
  end
  function src(input [1:0] s);
    src = s == 2'h0 ? (cm_r[7] ? xtal_osc_in : rx_tx_clock_pin_in) : s == 2'h1 ? bidir_clock_pin_in :
          s == 2'h2 ? div_out : loop_tx_clk;
  endfunction
  // expected mux outputs: the selected source as sampled at this edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ex_rx_r <= 1'b0;
      ex_tx_r <= 1'b0;
    end else begin
      ex_rx_r <= src(cm_r[6:5]);
      ex_tx_r <= src(cm_r[4:3]);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_XTAL_EN: assert property (stab |-> xtal_amp_en == cm_r[7])
    else $error("crystal enable differs from clock mode");
  AST_RX_SEL: assert property (stab |-> rx_clk == ex_rx_r)
    else $error("receive clock not from selected source");
  AST_TX_SEL: assert property (stab |-> tx_clk == ex_tx_r)
    else $error("transmit clock not from selected source");
  AST_BIDIR_OE: assert property (stab |-> bidir_clock_pin_oe ==
    (cm_r[2] && cm_r[6:5] != 2'h1 && cm_r[4:3] != 2'h1))
    else $error("bidir pin direction wrong");
  AST_BIDIR_HIGH: assert property (stab && bidir_clock_pin_oe && cm_r[1:0] == 2'h0 && !cm_r[7]
    |-> bidir_clock_pin_out) else $error("bidir pin not high with crystal off");
  AST_NO_SYNC: assert property (xtal_amp_en && $past(xtal_amp_en)
    |-> sync_out && !ext_sync_mode) else $error("sync used while crystal on");
  AST_DIV_FALL: assert property ($fell(div_out) |-> $past(zero_count))
    else $error("divider toggled away from zero count");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus response not ready okay");
  cover property ($fell(div_out));
  cover property (stab && bidir_clock_pin_oe);
  cover property (xtal_amp_en && sync_out);
endmodule // cmbg_chk
bind cmbg_top cmbg_chk i_cmbg_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .rx_tx_clock_pin_in, .bidir_clock_pin_in, .bidir_clock_pin_out, .bidir_clock_pin_oe, .loop_tx_clk,
  .xtal_osc_in, .xtal_amp_en, .rx_clk, .tx_clk, .sync_out, .ext_sync_mode, .div_out,
  .zero_count);

/* File: test/cmbg_clk_src.sv */
// model of the external clock pins, crystal and clock-recovery loop
module cmbg_clk_src (
  input  wire  hclk,
  input  wire  slow,
  input  wire  xtal_amp_en,
  input  wire  bidir_clock_pin_out,
  input  wire  bidir_clock_pin_oe,
  output logic rx_tx_clock_pin_in,
  output logic bidir_clock_pin_in,
  output logic sync_in,
  output logic loop_rx_clk,
  output logic loop_tx_clk,
  output logic xtal_osc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_r = 5'h00;
  logic       ph_r = 1'b0;
  logic       xon_r = 1'b0;
  // pins move on the falling edge so the block samples them settled
  always @(negedge hclk) begin
    ph_r <= ~ph_r;
    xon_r <= xtal_amp_en;
    if (!slow || ph_r) cnt_r <= cnt_r + 5'h01;
  end
  assign rx_tx_clock_pin_in = cnt_r[1];
  // far side lets go of the bidir pin while the block drives it
  assign bidir_clock_pin_in = bidir_clock_pin_oe ? bidir_clock_pin_out : cnt_r[2];
  assign sync_in = cnt_r[4];
  assign loop_rx_clk = cnt_r[3];
  assign loop_tx_clk = cnt_r[0];
  // crystal is flat until its amplifier runs
  assign xtal_osc_in = xon_r & ~cnt_r[3];
endmodule // cmbg_clk_src

/* File: test/test_cmbg_top.sv */
// self-checking bench for the clock mux and rate divider
module test_cmbg_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, sync_pulse_in, slow, er, et, p;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, rd, hrdata;
  wire         hreadyout, hresp, rx_tx_clock_pin_in, bidir_clock_pin_in, bidir_clock_pin_out, bidir_clock_pin_oe, sync_in, loop_rx_clk;
  wire         loop_tx_clk, xtal_osc_in, xtal_amp_en, rx_clk, tx_clk, sync_out, sync_oe;
  wire         ext_sync_mode, div_out, zero_count;
  int          error_cnt = 0, n_tests = 0, cyc = 0, n, z;
  cmbg_top i_cmbg_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_tx_clock_pin_in, .bidir_clock_pin_in, .bidir_clock_pin_out, .bidir_clock_pin_oe,
    .sync_in, .sync_pulse_in, .loop_rx_clk, .loop_tx_clk, .xtal_osc_in, .xtal_amp_en, .rx_clk,
    .tx_clk, .sync_out, .sync_oe, .ext_sync_mode, .div_out, .zero_count);
  cmbg_clk_src i_cmbg_clk_src (.hclk, .slow, .xtal_amp_en, .bidir_clock_pin_out, .bidir_clock_pin_oe, .rx_tx_clock_pin_in,
    .bidir_clock_pin_in, .sync_in, .loop_rx_clk, .loop_tx_clk, .xtal_osc_in);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // a hang costs a mismatch and ends the run
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      print_verdict;
    end
  end
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one single word transfer; the slave sets the pace through hreadyout
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  function logic src(input logic [1:0] s, input logic x);
    src = s == 2'h0 ? (x ? xtal_osc_in : rx_tx_clock_pin_in) : s == 2'h1 ? bidir_clock_pin_in :
          s == 2'h2 ? div_out : loop_tx_clk;
  endfunction
  task t_reset;
    chk(div_out, 1, "div out at reset");
    chk(zero_count, 1, "zero count at reset");
    chk(bidir_clock_pin_oe, 0, "bidir pin at reset");
    bus(1'b1, 8'h10, 32'h2);
    bus(1'b0, 8'h14, 32'h0);
    chk(rd[1], 1, "zero status enabled");
    bus(1'b1, 8'h10, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    chk(rd[1], 0, "zero status gated");
    bus(1'b0, 8'h1c, 32'h0);
    chk(rd, 0, "unmapped read");
    $display("test reset done");
  endtask
  // every source code on both muxes, with and without the crystal
  task t_mux;
    sync_pulse_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h00, {24'h0, i[2], i[1:0], ~i[1:0], 3'h0});
      repeat (3) @(posedge hclk);
      chk(xtal_amp_en, i[2], "crystal enable");
      repeat (8) begin
        @(posedge hclk);
        er = src(i[1:0], i[2]);
        et = src(~i[1:0], i[2]);
        #1;
        chk(rx_clk, er, "rx clock");
        chk(tx_clk, et, "tx clock");
      end
    end
    sync_pulse_in <= 1'b0;
    $display("test mux done");
  endtask
  // sync pin: direction, external sync, status and pulses on rising receive edges
  task t_sync;
    bus(1'b1, 8'h00, 32'h00);
    bus(1'b1, 8'h18, 32'h02);
    repeat (2) @(posedge hclk);
    chk(ext_sync_mode, 1, "external sync chosen");
    chk(sync_oe, 0, "sync pin input in external sync");
    @(negedge sync_in);
    bus(1'b0, 8'h14, 32'h0);
    chk(rd[4], 1, "sync status follows pin");
    bus(1'b1, 8'h18, 32'h00);
    sync_pulse_in <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(sync_oe, 1, "sync pin drives in sync mode");
    chk(ext_sync_mode, 0, "internal sync");
    @(posedge hclk);
    et = rx_clk;
    repeat (16) begin
      @(posedge hclk);
      er = ~(rx_clk & ~et);
      et = rx_clk;
      #1;
      chk(sync_out, er, "sync pulse on rising receive edge");
    end
    bus(1'b1, 8'h18, 32'h03);
    bus(1'b1, 8'h00, 32'h80);
    repeat (2) @(posedge hclk);
    chk(ext_sync_mode, 0, "no external sync with crystal");
    chk(sync_oe, 0, "no sync drive with crystal");
    @(negedge sync_in);
    bus(1'b0, 8'h14, 32'h0);
    chk(rd[4], 0, "sync status forced low");
    sync_pulse_in <= 1'b0;
    bus(1'b1, 8'h18, 32'h00);
    $display("test sync done");
  endtask
  logic [31:0] cm_inuse[2] = '{32'h24, 32'h0c};
  // bidir pin: direction, and every drive selection while it is an output
  task t_bidir;
    bus(1'b1, 8'h00, 32'h04);
    repeat (3) @(posedge hclk);
    chk(bidir_clock_pin_oe, 1, "bidir pin output");
    chk(bidir_clock_pin_out, 1, "crystal off drives high");
    for (int k = 1; k < 4; k++) begin
      bus(1'b1, 8'h00, 32'h04 | k);
      repeat (3) @(posedge hclk);
      repeat (8) begin
        @(posedge hclk);
        er = k == 1 ? div_out : k == 2 ? loop_rx_clk : tx_clk;
        #1;
        chk(bidir_clock_pin_out, er, "bidir pin drive selection");
      end
    end
    foreach (cm_inuse[j]) begin
      bus(1'b1, 8'h00, cm_inuse[j]);
      repeat (3) @(posedge hclk);
      chk(bidir_clock_pin_oe, 0, "bidir pin in use as source");
    end
    $display("test bidir done");
  endtask
  // cycles from one falling output edge to the next, and zero-count cycles between
  task wait_fall;
    n = 0;
    z = 0;
    do begin
      p = div_out;
      @(negedge hclk);
      n++;
      z += zero_count;
    end while (!(p === 1'b1 && div_out === 1'b0));
  endtask
  // stop, load constant low byte first, pick clock, start and time one period
  task t_period(input logic [7:0] ctl, input logic [15:0] tc, input int tick);
    bus(1'b1, 8'h0c, {30'h0, ctl[1], 1'b0});
    bus(1'b1, 8'h04, {24'h0, tc[7:0]});
    bus(1'b1, 8'h08, {24'h0, tc[15:8]});
    bus(1'b1, 8'h0c, {24'h0, ctl});
    repeat (3 * tick + 2) @(negedge hclk);
    chk(div_out, 1, "start-up output high");
    wait_fall;
    wait_fall;
    chk(n, 2 * (tc + 1) * tick, "divider period");
    chk(z, 2 * tick, "zero count duration");
  endtask
  task t_div;
    t_period(8'h03, 16'h0103, 1);
    bus(1'b1, 8'h0c, 32'h2);
    p = div_out;
    n = 0;
    repeat (600) @(negedge hclk) n += (div_out !== p);
    chk(n, 0, "divider stopped");
    slow <= 1'b1;
    t_period(8'h01, 16'h0001, 16);
    $display("test divider done");
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sync_pulse_in = 1'b0;
    slow = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_mux;
    t_sync;
    t_bidir;
    t_div;
    print_verdict;
  end
endmodule // test_cmbg_top
